// ---- hdl/dps_defines.svh ----
/*
  Constants for the semaphore flag port controller.
  Assumes it is included by bare name from files under hdl/.
*/
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_FLAG_COUNT 4'h8
`define DPS_IDX_W 3
`define DPS_DATA_W 8
`define DPS_ADDR_W 16
`define DPS_LAST_IDX 3'h7
`define DPS_PHASE_CYC 2'h2
`define DPS_GAP_CYC 2'h1
`endif

// ---- hdl/dps_host.sv ----
/*
  One-port controller for the semaphore flags of a dual-port memory.
  It runs read, request, release and start-up commands one at a time,
  and reports each end with a one-cycle response pulse.
  Assumes the device pins are wired to this module's pin ports and that
  the board resolves the data bus from the output enable.
  Assumes the command side runs on the same clock, while the data pins
  are asynchronous and pass through a two-stage synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dps_defines.svh"
module dps_host (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire dps_pkg::dps_op_type CMD_OP,
  input wire logic [`DPS_IDX_W-1:0] CMD_INDEX,
  output logic RSP_VALID,
  output logic RSP_OWNED,
  output logic [`DPS_DATA_W-1:0] RSP_DATA,
  output logic FLAG_SPACE_SELECT_N,
  output logic CE_N,
  output logic RW_N,
  output logic OE_N,
  output logic [`DPS_ADDR_W-1:0] ADDR,
  output logic [`DPS_DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic [`DPS_DATA_W-1:0] DATA_IN
);
  import dps_pkg::*;

  dps_state_type state_ff;
  dps_state_type nxt_state;
  dps_op_type op_ff;
  dps_op_type nxt_op;
  logic [`DPS_IDX_W-1:0] idx_ff;
  logic [`DPS_IDX_W-1:0] nxt_idx;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic rd_ff;
  logic nxt_rd;
  logic sel_n_ff;
  logic nxt_sel_n;
  logic rw_n_ff;
  logic nxt_rw_n;
  logic oe_n_ff;
  logic nxt_oe_n;
  logic dq_oe_ff;
  logic nxt_dq_oe;
  logic bit0_ff;
  logic nxt_bit0;
  logic rsp_v_ff;
  logic nxt_rsp_v;
  logic owned_ff;
  logic nxt_owned;
  logic [`DPS_DATA_W-1:0] rdata_ff;
  logic [`DPS_DATA_W-1:0] nxt_rdata;
  logic [`DPS_DATA_W-1:0] din_s;

  // Picks the value written on data bit zero for a write operation.
  // Only a request writes a zero; release and start-up write a one.
  function automatic logic op_bit(input dps_op_type op);
    op_bit = (op != DPS_OP_REQUEST);
  endfunction

  // Data pins come from another domain and are synchronised first.
  // The two stages cost two cycles, so a read is sampled late in its phase.
  dps_sync2 #(.WIDTH(`DPS_DATA_W)) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .din(DATA_IN),
    .dout(din_s)
  );

  // Sequencer: each access drives select for three cycles, then holds it
  // high for a gap before the next access or the response.
  // A read takes the command, drives three cycles, waits out the gap and
  // pulses the response seven cycles after the take.
  // A request runs a write phase and a read-back phase back to back.
  // Start-up runs eight write phases, one for each flag index.
  // The read data is taken from the synchroniser as select drops, which
  // holds the pin value seen early in the phase.
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_idx = idx_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_sel_n = sel_n_ff;
    nxt_rw_n = rw_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_bit0 = bit0_ff;
    nxt_rsp_v = 1'b0;
    nxt_owned = owned_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      // Waits for a command and starts its first phase.
      DPS_IDLE: begin
        if (CMD_VALID) begin
          nxt_op = CMD_OP;
          nxt_idx = (CMD_OP == DPS_OP_INIT) ? '0 : CMD_INDEX;
          // A request writes first and reads back afterwards.
          nxt_rd = (CMD_OP == DPS_OP_READ);
          nxt_bit0 = op_bit(CMD_OP);
          nxt_sel_n = 1'b0;
          nxt_rw_n = (CMD_OP == DPS_OP_READ);
          nxt_oe_n = (CMD_OP != DPS_OP_READ);
          nxt_dq_oe = (CMD_OP != DPS_OP_READ);
          nxt_cnt = `DPS_PHASE_CYC;
          nxt_state = DPS_DRIVE;
        end
      end
      // Holds the pins of one access until its count runs out.
      DPS_DRIVE: begin
        if (cnt_ff != 2'h0) begin
          nxt_cnt = cnt_ff - 2'h1;
        end else begin
          if (rd_ff) begin
            // Any set bit means the flag reads one, so the token is not ours.
            nxt_rdata = din_s;
            nxt_owned = ~|din_s;
          end
          // Select drops so the next read latches a fresh value.
          nxt_sel_n = 1'b1;
          nxt_rw_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_dq_oe = 1'b0;
          nxt_cnt = `DPS_GAP_CYC;
          nxt_state = DPS_GAP;
        end
      end
      // Keeps select high, then chooses the next phase or the end.
      DPS_GAP: begin
        if (cnt_ff != 2'h0) begin
          nxt_cnt = cnt_ff - 2'h1;
        end else if (op_ff == DPS_OP_REQUEST && !rd_ff) begin
          // Read back the flag just requested; the result stays visible.
          nxt_rd = 1'b1;
          nxt_sel_n = 1'b0;
          nxt_oe_n = 1'b0;
          nxt_cnt = `DPS_PHASE_CYC;
          nxt_state = DPS_DRIVE;
        end else if (op_ff == DPS_OP_INIT && idx_ff != `DPS_LAST_IDX) begin
          // Start-up frees every flag in turn.
          nxt_idx = idx_ff + 3'h1;
          nxt_sel_n = 1'b0;
          nxt_rw_n = 1'b0;
          nxt_dq_oe = 1'b1;
          nxt_cnt = `DPS_PHASE_CYC;
          nxt_state = DPS_DRIVE;
        end else begin
          if (op_ff != DPS_OP_READ && op_ff != DPS_OP_REQUEST) begin
            nxt_owned = 1'b0;
          end
          nxt_state = DPS_DONE;
        end
      end
      // Pulses the response; ready rises in the same cycle.
      DPS_DONE: begin
        nxt_rsp_v = 1'b1;
        nxt_state = DPS_IDLE;
      end
      // An illegal state code returns to idle.
      default: begin
        nxt_state = DPS_IDLE;
      end
    endcase
  end

  // Registers only; every pin idles inactive after reset.
  // The reset is synchronous, so the pins settle at the first edge that samples it low.
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      state_ff <= DPS_IDLE;
      op_ff <= DPS_OP_READ;
      idx_ff <= '0;
      cnt_ff <= 2'h0;
      rd_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      rw_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      bit0_ff <= 1'b1;
      rsp_v_ff <= 1'b0;
      owned_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      sel_n_ff <= nxt_sel_n;
      rw_n_ff <= nxt_rw_n;
      oe_n_ff <= nxt_oe_n;
      dq_oe_ff <= nxt_dq_oe;
      bit0_ff <= nxt_bit0;
      rsp_v_ff <= nxt_rsp_v;
      owned_ff <= nxt_owned;
      rdata_ff <= nxt_rdata;
    end
  end

  // Pin drive: memory enable held high, flag index on the low address bits.
  // Upper address bits and upper data bits are fixed, since the device
  // ignores them during flag accesses.
  assign CE_N = 1'b1;
  assign FLAG_SPACE_SELECT_N = sel_n_ff;
  assign RW_N = rw_n_ff;
  assign OE_N = oe_n_ff;
  assign ADDR = {{(`DPS_ADDR_W-`DPS_IDX_W){1'b0}}, idx_ff};
  assign DATA_OUT = {{(`DPS_DATA_W-1){1'b1}}, bit0_ff};
  assign DATA_OE = dq_oe_ff;
  assign CMD_READY = (state_ff == DPS_IDLE);
  assign RSP_VALID = rsp_v_ff;
  assign RSP_OWNED = owned_ff;
  assign RSP_DATA = rdata_ff;
endmodule
`default_nettype wire

// ---- hdl/dps_pkg.sv ----
/*
  Types for the semaphore flag port controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dps_pkg;
  typedef enum logic [3:0] {
    DPS_IDLE = 4'b0001,
    DPS_DRIVE = 4'b0010,
    DPS_GAP = 4'b0100,
    DPS_DONE = 4'b1000
  } dps_state_type;
  typedef enum logic [1:0] {
    DPS_OP_READ = 2'h0,
    DPS_OP_REQUEST = 2'h1,
    DPS_OP_RELEASE = 2'h2,
    DPS_OP_INIT = 2'h3
  } dps_op_type;
endpackage

// ---- hdl/dps_sync2.sv ----
/*
  Two flip-flop synchroniser for a vector of pin inputs.
  Assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module dps_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  // Both stages clear to zero at reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;
endmodule
`default_nettype wire

// ---- testbench/dps_checker.sv ----
/* Assertions on the flag port pins and read response of the host controller.
   Assumes it is bound into the host controller by port name. */
`timescale 1ns/100ps
`default_nettype none
module dps_checker (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire dps_pkg::dps_op_type CMD_OP,
  input wire logic RSP_VALID,
  input wire logic FLAG_SPACE_SELECT_N,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE
);
  import dps_pkg::*;
  logic take;
  // A command is taken at an edge where valid meets ready.
  assign take = CMD_VALID && CMD_READY;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // Pin relations of the flag port, and the read response time.
  chk_ce_held: assert property (CE_N) else $error("ce low");
  chk_addr_upper: assert property (!FLAG_SPACE_SELECT_N |-> ADDR[15:3] == 13'h0)
    else $error("high address");
  chk_data_bits: assert property (DATA_OE |-> DATA_OUT[7:1] == 7'h7f)
    else $error("data bits");
  chk_no_fight: assert property (DATA_OE |-> OE_N) else $error("bus fight");
  chk_poll_gap: assert property ($rose(FLAG_SPACE_SELECT_N) |=> FLAG_SPACE_SELECT_N)
    else $error("short gap");
  chk_req_write: assert property (take && CMD_OP == DPS_OP_REQUEST |=> !DATA_OUT[0])
    else $error("request bit");
  chk_rel_write: assert property (take && CMD_OP == DPS_OP_RELEASE |=> DATA_OUT[0])
    else $error("release bit");
  chk_read_time: assert property (take && CMD_OP == DPS_OP_READ |-> ##7 RSP_VALID)
    else $error("read late");
endmodule
`default_nettype wire

// ---- testbench/dps_flag_model.sv ----
/* Flag device model; its far port is worked by the bench.
   Assumes host pins change just after the clock edge. */
`timescale 1ns/100ps
`default_nettype none
module dps_flag_model (
  input wire logic clk,
  input wire logic sel_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] dout,
  input wire logic doe,
  output logic [7:0] din,
  input wire logic far_wr,
  input wire logic [2:0] far_idx,
  input wire logic far_bit
);
  // Request latches, and owner per flag: 0 free, 1 host, 2 far port.
  logic [7:0] req_l = 8'hff;
  logic [7:0] req_r = 8'hff;
  logic [1:0] own [8] = '{default: 2'h0};
  logic [7:0] rd_ff = 8'h00;
  logic rd_on = 1'b0;
  logic [2:0] i;
  assign i = addr[2:0];
  // Writes from both ports; a tie leaves exactly one owner.
  always @(posedge clk) begin
    if (!sel_n && !rw_n && doe) begin
      req_l[i] <= dout[0];
      if (!dout[0] && own[i] == 2'h0) own[i] <= 2'h1;
      if (dout[0] && own[i] == 2'h1) own[i] <= req_r[i] ? 2'h0 : 2'h2;
    end
    if (far_wr) begin
      req_r[far_idx] <= far_bit;
      if (!far_bit && own[far_idx] == 2'h0) own[far_idx] <= 2'h2;
      if (far_bit && own[far_idx] == 2'h2) own[far_idx] <= req_l[far_idx] ? 2'h0 : 2'h1;
    end
    if (!sel_n && !oe_n && !rd_on) rd_ff <= {8{own[i] != 2'h1}};
    rd_on <= !sel_n && !oe_n;
  end
  // A released bus shows the inverse of the last value.
  assign din = (sel_n || oe_n) ? ~rd_ff : rd_on ? rd_ff : {8{own[i] != 2'h1}};
endmodule
`default_nettype wire

// ---- testbench/dps_host_bench.sv ----
/* Bench for the host flag controller against the device model.
   Assumes design, checker and model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module dps_host_bench;
  import dps_pkg::*;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic CMD_VALID = 1'b0;
  dps_op_type CMD_OP = DPS_OP_READ;
  logic [2:0] CMD_INDEX = 3'h0;
  logic CMD_READY, RSP_VALID, RSP_OWNED, FLAG_SPACE_SELECT_N, CE_N, RW_N, OE_N, DATA_OE;
  logic [7:0] RSP_DATA, DATA_OUT, DATA_IN;
  logic [15:0] ADDR;
  logic far_wr = 1'b0;
  logic [2:0] far_idx = 3'h0;
  logic far_bit = 1'b1;
  int fails = 0;
  int n_compared = 0;
  // Controller and the device it drives.
  dps_host dps_host_inst (.MCLK(MCLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_INDEX(CMD_INDEX), .RSP_VALID(RSP_VALID),
    .RSP_OWNED(RSP_OWNED), .RSP_DATA(RSP_DATA), .FLAG_SPACE_SELECT_N(FLAG_SPACE_SELECT_N),
    .CE_N(CE_N), .RW_N(RW_N), .OE_N(OE_N), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .DATA_IN(DATA_IN));
  dps_flag_model dps_flag_model_inst (.clk(MCLK), .sel_n(FLAG_SPACE_SELECT_N), .rw_n(RW_N),
    .oe_n(OE_N), .addr(ADDR), .dout(DATA_OUT), .doe(DATA_OE), .din(DATA_IN),
    .far_wr(far_wr), .far_idx(far_idx), .far_bit(far_bit));
  initial forever #25 MCLK = ~MCLK;
  // Compares one value and counts it.
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Runs one command and judges its response.
  task automatic run(input dps_op_type op, input logic [2:0] idx, input logic own,
    input logic [7:0] data);
    int n;
    n = 0;
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_INDEX = idx;
    while (CMD_READY !== 1'b1) @(posedge MCLK) #1;
    @(posedge MCLK) #1;
    CMD_VALID = 1'b0;
    while (RSP_VALID !== 1'b1 && n < 100) begin
      @(posedge MCLK) #1;
      n++;
    end
    if (n >= 100) begin
      fails++;
      $display("Error RSP_VALID expected 1 seen 0");
    end
    check8("owned", {7'h00, own}, {7'h00, RSP_OWNED});
    if (op == DPS_OP_READ || op == DPS_OP_REQUEST) check8("data", data, RSP_DATA);
  endtask
  // One write from the far port.
  task automatic far(input logic [2:0] idx, input logic b);
    far_wr = 1'b1;
    far_idx = idx;
    far_bit = b;
    @(posedge MCLK) #1;
    far_wr = 1'b0;
    @(posedge MCLK) #1;
  endtask
  task automatic test_init();
    for (int k = 0; k < 8; k++) far(k[2:0], 1'b1);
    run(DPS_OP_INIT, 3'h3, 1'b0, 8'hff);
    run(DPS_OP_READ, 3'h7, 1'b0, 8'hff);
    $display("test_init done");
  endtask
  task automatic test_claim();
    run(DPS_OP_REQUEST, 3'h5, 1'b1, 8'h00);
    run(DPS_OP_READ, 3'h5, 1'b1, 8'h00);
    far(3'h5, 1'b0);
    run(DPS_OP_READ, 3'h5, 1'b1, 8'h00);
    run(DPS_OP_RELEASE, 3'h5, 1'b0, 8'h00);
    run(DPS_OP_READ, 3'h5, 1'b0, 8'hff);
    $display("test_claim done");
  endtask
  task automatic test_locked();
    run(DPS_OP_REQUEST, 3'h5, 1'b0, 8'hff);
    run(DPS_OP_REQUEST, 3'h2, 1'b1, 8'h00);
    run(DPS_OP_RELEASE, 3'h5, 1'b0, 8'hff);
    far(3'h5, 1'b1);
    run(DPS_OP_REQUEST, 3'h5, 1'b1, 8'h00);
    $display("test_locked done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the fewer than two hundred cycles the tests need.
  initial begin
    #250000;
    fails++;
    test_done();
  end
  // Reset for four cycles, then the tests in turn.
  initial begin
    repeat (4) @(posedge MCLK);
    #1 RESETN = 1'b1;
    test_init();
    test_claim();
    test_locked();
    test_done();
  end
endmodule
bind dps_host dps_checker dps_checker_inst (.MCLK(MCLK), .RESETN(RESETN),
  .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .RSP_VALID(RSP_VALID),
  .FLAG_SPACE_SELECT_N(FLAG_SPACE_SELECT_N), .CE_N(CE_N), .OE_N(OE_N), .ADDR(ADDR),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
`default_nettype wire
